// >>> common/dtc_bus_if.sv
// parallel bus pins between host controller and target
`timescale 1ns/1ps
interface dtc_bus_if;
	logic       chip_sel_n;
	logic       ale;
	logic       cle;
	logic       write_en_n;
	logic       read_strobe_n;
	logic [7:0] dq_h;
	logic       dq_h_oe_n;
	logic       dqs_h;
	logic       dqs_h_oe_n;
	logic [7:0] dq_d;
	logic       dq_d_oe_n;
	logic       dqs_d;
	logic       dqs_d_oe_n;
	logic       ready_busy_n;
	modport host (
		output chip_sel_n, ale, cle, write_en_n, read_strobe_n,
		output dq_h, dq_h_oe_n, dqs_h, dqs_h_oe_n,
		input  dq_d, dq_d_oe_n, dqs_d, dqs_d_oe_n, ready_busy_n
	);
	modport device (
		input  chip_sel_n, ale, cle, write_en_n, read_strobe_n,
		input  dq_h, dq_h_oe_n, dqs_h, dqs_h_oe_n,
		output dq_d, dq_d_oe_n, dqs_d, dqs_d_oe_n, ready_busy_n
	);
endinterface

// >>> common/dtc_defs.svh
// constants for the die termination control block
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH
`define DTC_CMD_SET_FEATURES 8'hef
`define DTC_CMD_MATRIX       8'he2
`define DTC_CMD_VOL_SELECT   8'he1
`define DTC_CMD_RESET        8'hff
`define DTC_CMD_SYNC_RESET   8'hfc
`define DTC_CMD_LUN_RESET    8'hfa
`define DTC_CMD_FULL_RESET   8'hfd
`define DTC_CMD_READ         8'h00
`define DTC_CMD_PROG         8'h80
`define DTC_OUT_NIB_HI       7
`define DTC_OUT_NIB_LO       4
`define DTC_IN_NIB_HI        3
`define DTC_IN_NIB_LO        0
`define DTC_CFG_RESET        8'h00
`define DTC_BUSY_NS          200
`define DTC_BUSY_CYC         (((`DTC_BUSY_NS) + 9) / 10)
`define DTC_HOST_DIV         4
`endif

// >>> common/dtc_pkg.sv
// types shared by both ends of the termination link
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_LUN_DESEL,
		DTC_LUN_SNIFF,
		DTC_LUN_SEL
	} dtc_lun_state_e;
	typedef enum logic [1:0] {
		DTC_CYC_IDLE,
		DTC_CYC_CMDADR,
		DTC_CYC_DIN,
		DTC_CYC_DOUT
	} dtc_cyc_e;
	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] mask_hi;
		logic [7:0] data_val;
		logic [7:0] rs_val;
	} dtc_cfg_s;
endpackage

// >>> core/dtc_host.sv
// host end: issues commands and configuration bytes
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_host (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	dtc_bus_if.host         bus,
	input  wire logic       req_valid,
	input  wire logic [1:0] req_kind,
	input  wire logic [7:0] req_cmd,
	input  wire logic [7:0] req_addr,
	input  wire logic [31:0] req_data,
	input  wire logic       req_release,
	output logic            req_ready
);
	import dtc_pkg::*;

	typedef enum logic [2:0] {
		DTC_H_IDLE,
		DTC_H_CMD,
		DTC_H_ADR,
		DTC_H_DAT,
		DTC_H_OFF,
		DTC_H_EXIT
	} dtc_hst_e;

	// bus slow-rate enable
	logic [2:0] div_r, div_nxt;
	logic       tick;
	assign tick = div_r == 3'(`DTC_HOST_DIV - 1);
	assign div_nxt = tick ? 3'h0 : div_r + 3'h1;

	dtc_hst_e   st_r, st_nxt;
	logic       ph_r, ph_nxt;
	logic [2:0] n_r, n_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [7:0] adr_r, adr_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic [1:0] kind_r, kind_nxt;
	logic       cs_n_nxt, ale_nxt, cle_nxt, we_nxt;
	logic [7:0] dq_nxt;
	logic       rdy_nxt;
	logic       rs_nxt;
	logic       dqs_nxt;
	logic       oe_n_nxt;

	// one byte per two ticks: strobe low then high
	always_comb begin
		st_nxt = st_r;
		ph_nxt = ph_r;
		n_nxt = n_r;
		cmd_nxt = cmd_r;
		adr_nxt = adr_r;
		dat_nxt = dat_r;
		kind_nxt = kind_r;
		cs_n_nxt = bus.chip_sel_n;
		ale_nxt = 1'b0;
		cle_nxt = 1'b0;
		we_nxt = 1'b1;
		dq_nxt = bus.dq_h;
		rdy_nxt = 1'b0;
		rs_nxt = 1'b1;
		dqs_nxt = 1'b1;
		oe_n_nxt = 1'b0;
		case (st_r)
			DTC_H_IDLE: begin
				rdy_nxt = 1'b1;
				if (req_release) begin
					cs_n_nxt = 1'b1;
					st_nxt = DTC_H_OFF;
				end else if (req_valid) begin
					cmd_nxt = req_cmd;
					adr_nxt = req_addr;
					dat_nxt = req_data;
					kind_nxt = req_kind;
					cs_n_nxt = 1'b0;
					ph_nxt = 1'b0;
					n_nxt = 3'h0;
					rdy_nxt = 1'b0;
					st_nxt = DTC_H_CMD;
				end
			end
			DTC_H_CMD: if (tick) begin
				cle_nxt = 1'b1;
				dq_nxt = cmd_r;
				we_nxt = ph_r;
				ph_nxt = !ph_r;
				if (ph_r) begin
					st_nxt = (kind_r == 2'h0) ? DTC_H_IDLE : DTC_H_ADR;
				end
			end else begin
				cle_nxt = bus.cle;
				we_nxt = bus.write_en_n;
			end
			DTC_H_ADR: if (tick) begin
				ale_nxt = 1'b1;
				dq_nxt = adr_r;
				we_nxt = ph_r;
				ph_nxt = !ph_r;
				if (ph_r) begin
					st_nxt = (kind_r == 2'h1) ? DTC_H_IDLE : DTC_H_DAT;
				end
			end else begin
				ale_nxt = bus.ale;
				we_nxt = bus.write_en_n;
			end
			// program data on the strobe, read data on the read strobe
			DTC_H_DAT: if (tick) begin
				dq_nxt = dat_r[31:24];
				ph_nxt = !ph_r;
				if (cmd_r == `DTC_CMD_PROG) begin
					dqs_nxt = ph_r;
				end else if (cmd_r == `DTC_CMD_READ) begin
					rs_nxt = ph_r;
					oe_n_nxt = 1'b1; // bus released for output
				end else begin
					we_nxt = ph_r;
				end
				if (ph_r) begin
					dat_nxt = {dat_r[23:0], 8'h00};
					n_nxt = n_r + 3'h1;
					if (n_r == 3'h3) begin
						st_nxt = DTC_H_EXIT;
					end
				end
			end else begin
				we_nxt = bus.write_en_n;
				rs_nxt = bus.read_strobe_n;
				dqs_nxt = bus.dqs_h;
				oe_n_nxt = bus.dq_h_oe_n;
			end
			// close the burst: one tick of cle with no write strobe
			DTC_H_EXIT: if (tick) begin
				cle_nxt = !ph_r;
				ph_nxt = !ph_r;
				if (ph_r) begin
					st_nxt = DTC_H_IDLE;
				end
			end else begin
				cle_nxt = bus.cle;
				oe_n_nxt = bus.dq_h_oe_n;
			end
			DTC_H_OFF: begin
				rdy_nxt = 1'b1;
				if (req_valid) begin
					cs_n_nxt = 1'b0;
					rdy_nxt = 1'b0;
					st_nxt = DTC_H_IDLE;
				end
			end
			default: st_nxt = DTC_H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_r <= 3'h0;
			st_r <= DTC_H_OFF;
			ph_r <= 1'b0;
			n_r <= 3'h0;
			cmd_r <= 8'h00;
			adr_r <= 8'h00;
			dat_r <= 32'h0;
			kind_r <= 2'h0;
			req_ready <= 1'b0;
			bus.chip_sel_n <= 1'b1;
			bus.ale <= 1'b0;
			bus.cle <= 1'b0;
			bus.write_en_n <= 1'b1;
			bus.read_strobe_n <= 1'b1;
			bus.dq_h <= 8'h00;
			bus.dq_h_oe_n <= 1'b0;
			bus.dqs_h <= 1'b1;
			bus.dqs_h_oe_n <= 1'b0;
		end else begin
			div_r <= div_nxt;
			st_r <= st_nxt;
			ph_r <= ph_nxt;
			n_r <= n_nxt;
			cmd_r <= cmd_nxt;
			adr_r <= adr_nxt;
			dat_r <= dat_nxt;
			kind_r <= kind_nxt;
			req_ready <= rdy_nxt;
			bus.chip_sel_n <= cs_n_nxt;
			bus.ale <= ale_nxt;
			bus.cle <= cle_nxt;
			bus.write_en_n <= we_nxt;
			bus.read_strobe_n <= rs_nxt;
			bus.dq_h <= dq_nxt;
			bus.dq_h_oe_n <= oe_n_nxt;
			bus.dqs_h <= dqs_nxt;
			bus.dqs_h_oe_n <= oe_n_nxt;
		end
	end
endmodule

// >>> core/dtc_target.sv
// target end: per-LUN termination state and control
`timescale 1ns/1ps
`include "dtc_defs.svh"
module dtc_target #(
	parameter int NUM_LUNS = 2,
	parameter int MY_VOLUME = 0
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	dtc_bus_if.device       bus,
	output logic [NUM_LUNS-1:0] term_dq_on,
	output logic [NUM_LUNS-1:0] term_rs_on,
	output logic [3:0]          term_dq_val,
	output logic [7:0]          term_rs_val,
	output logic                matrix_mode,
	output logic                standby,
	output logic                bus_idle
);
	import dtc_pkg::*;

	// two-flop synchronisers for the pins
	logic [13:0] s1_r;
	logic [13:0] s2_r;
	logic [13:0] pin_raw;
	assign pin_raw = {bus.chip_sel_n, bus.ale, bus.cle, bus.write_en_n,
		bus.read_strobe_n, bus.dqs_h, bus.dq_h};
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_r <= 14'h3fff;
			s2_r <= 14'h3fff;
		end else begin
			s1_r <= pin_raw;
			s2_r <= s1_r;
		end
	end
	logic       cs_n;
	logic       ale;
	logic       cle;
	logic       we_n;
	logic       rs_n;
	logic       dqs;
	logic [7:0] dq;
	assign {cs_n, ale, cle, we_n, rs_n, dqs, dq} = s2_r;

	// decoded volume bitmask test
	function automatic logic vol_hit(input logic [7:0] m, input int v);
		vol_hit = m[v[2:0]];
	endfunction

	// command, address and configuration state
	logic                we_d_r;
	logic [7:0]          cmd_r, cmd_nxt;
	logic [2:0]          acnt_r, acnt_nxt;
	logic [7:0]          sel_vol_r, sel_vol_nxt;
	logic                odt_en_r, odt_en_nxt;
	logic                matrix_r, matrix_nxt;
	logic [0:0]          lun_r, lun_nxt;
	dtc_cfg_s            cfg_r [NUM_LUNS];
	dtc_cfg_s            cfg_nxt [NUM_LUNS];
	dtc_cyc_e            cyc_r, cyc_nxt;
	logic [15:0]         busy_r, busy_nxt;
	logic                we_rise;
	logic                idle_c;
	assign we_rise = we_n && !we_d_r;
	assign idle_c = !cs_n && !ale && !cle && rs_n && dqs
		&& busy_r == 16'h0000 && cyc_r != DTC_CYC_DIN
		&& cyc_r != DTC_CYC_DOUT;

	always_comb begin
		cmd_nxt = cmd_r;
		acnt_nxt = acnt_r;
		sel_vol_nxt = sel_vol_r;
		odt_en_nxt = odt_en_r;
		matrix_nxt = matrix_r;
		lun_nxt = lun_r;
		cyc_nxt = cyc_r;
		busy_nxt = (busy_r != 16'h0000) ? busy_r - 16'h0001 : busy_r;
		for (int i = 0; i < NUM_LUNS; i++) begin
			cfg_nxt[i] = cfg_r[i];
		end
		if (cs_n) begin
			cyc_nxt = DTC_CYC_IDLE;
		end else if (ale || cle) begin
			cyc_nxt = DTC_CYC_CMDADR;
		end else if (!rs_n && cmd_r == `DTC_CMD_READ) begin
			cyc_nxt = DTC_CYC_DOUT;
		end else if (!dqs && cmd_r == `DTC_CMD_PROG) begin
			cyc_nxt = DTC_CYC_DIN;
		end
		// latches only on a write strobe edge; idle_c ignores it, so configuration bytes can latch while idle_c holds
		if (!cs_n && we_rise && cle && !ale) begin
			cmd_nxt = dq;
			acnt_nxt = 3'h0;
			if (dq == `DTC_CMD_FULL_RESET) begin
				cfg_nxt[lun_r] = '0;
				busy_nxt = 16'(`DTC_BUSY_CYC);
			end else if (dq == `DTC_CMD_RESET || dq == `DTC_CMD_SYNC_RESET
				|| dq == `DTC_CMD_LUN_RESET) begin
				busy_nxt = 16'(`DTC_BUSY_CYC);
			end
		end else if (!cs_n && we_rise && ale && !cle) begin
			acnt_nxt = acnt_r + 3'h1;
			case (cmd_r)
				`DTC_CMD_VOL_SELECT: sel_vol_nxt = dq;
				`DTC_CMD_MATRIX: lun_nxt = dq[0:0];
				`DTC_CMD_SET_FEATURES: ;
				default: ;
			endcase
		end else if (!cs_n && we_rise && !ale && !cle) begin
			acnt_nxt = acnt_r + 3'h1;
			case (cmd_r)
				`DTC_CMD_SET_FEATURES: begin
					if (acnt_r == 3'h1) begin
						odt_en_nxt = dq[0];
					end
				end
				`DTC_CMD_MATRIX: begin
					matrix_nxt = 1'b1;
					case (acnt_r)
						3'h1: cfg_nxt[lun_r].mask = dq;
						3'h2: cfg_nxt[lun_r].mask_hi = dq;
						3'h3: cfg_nxt[lun_r].data_val = dq;
						3'h4: cfg_nxt[lun_r].rs_val = dq;
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			we_d_r <= 1'b1;
			cmd_r <= 8'h00;
			acnt_r <= 3'h0;
			sel_vol_r <= 8'h00;
			odt_en_r <= 1'b0;
			matrix_r <= 1'b0;
			lun_r <= 1'b0;
			cyc_r <= DTC_CYC_IDLE;
			busy_r <= 16'h0000;
			for (int i = 0; i < NUM_LUNS; i++) begin
				cfg_r[i] <= {4{`DTC_CFG_RESET}};
			end
		end else begin
			we_d_r <= we_n;
			cmd_r <= cmd_nxt;
			acnt_r <= acnt_nxt;
			sel_vol_r <= sel_vol_nxt;
			odt_en_r <= odt_en_nxt;
			matrix_r <= matrix_nxt;
			lun_r <= lun_nxt;
			cyc_r <= cyc_nxt;
			busy_r <= busy_nxt;
			for (int i = 0; i < NUM_LUNS; i++) begin
				cfg_r[i] <= cfg_nxt[i];
			end
		end
	end

	// per-LUN state and termination outputs
	dtc_lun_state_e      st [NUM_LUNS];
	logic [NUM_LUNS-1:0] dq_on_nxt;
	logic [NUM_LUNS-1:0] rs_on_nxt;
	always_comb begin
		dq_on_nxt = '0;
		rs_on_nxt = '0;
		for (int i = 0; i < NUM_LUNS; i++) begin
			logic term;
			logic zero;
			logic data_cyc;
			term = vol_hit(cfg_r[i].mask, int'(sel_vol_r[2:0]));
			zero = cfg_r[i] == '0;
			data_cyc = !cs_n && !ale && !cle;
			if (sel_vol_r[2:0] == 3'(MY_VOLUME)) begin
				st[i] = DTC_LUN_SEL;
			end else if (term && !zero) begin
				st[i] = DTC_LUN_SNIFF;
			end else begin
				st[i] = DTC_LUN_DESEL;
			end
			if (cs_n || !odt_en_r) begin
				dq_on_nxt[i] = 1'b0;
			end else if (!matrix_r) begin
				// self mode: executing LUN only
				if (i == int'(lun_r)) begin
					dq_on_nxt[i] = cyc_r == DTC_CYC_DIN;
					rs_on_nxt[i] = cyc_r == DTC_CYC_DOUT;
				end
			end else if (!zero) begin
				case (st[i])
					DTC_LUN_SEL: begin
						dq_on_nxt[i] = term && ((cyc_r == DTC_CYC_DIN
							&& cfg_r[i].data_val[3:0] != 4'h0)
							|| (cyc_r == DTC_CYC_DOUT
							&& cfg_r[i].data_val[7:4] != 4'h0));
						rs_on_nxt[i] = term && cyc_r == DTC_CYC_DOUT
							&& cfg_r[i].rs_val != 8'h00;
					end
					DTC_LUN_SNIFF: begin
						dq_on_nxt[i] = data_cyc && ((!dqs
							&& cfg_r[i].data_val[3:0] != 4'h0)
							|| (!rs_n && cfg_r[i].data_val[7:4] != 4'h0));
						rs_on_nxt[i] = data_cyc && !rs_n
							&& cfg_r[i].rs_val != 8'h00;
					end
					default: ;
				endcase
			end
		end
	end

	// registered outputs and pin drive
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			term_dq_on <= '0;
			term_rs_on <= '0;
			term_dq_val <= 4'h0;
			term_rs_val <= 8'h00;
			matrix_mode <= 1'b0;
			standby <= 1'b0;
			bus_idle <= 1'b0;
			bus.dq_d <= 8'h00;
			bus.dq_d_oe_n <= 1'b1;
			bus.dqs_d <= 1'b1;
			bus.dqs_d_oe_n <= 1'b1;
			bus.ready_busy_n <= 1'b1;
		end else begin
			term_dq_on <= dq_on_nxt;
			term_rs_on <= rs_on_nxt;
			term_dq_val <= (cyc_r == DTC_CYC_DOUT)
				? cfg_r[lun_r].data_val[`DTC_OUT_NIB_HI:`DTC_OUT_NIB_LO]
				: cfg_r[lun_r].data_val[`DTC_IN_NIB_HI:`DTC_IN_NIB_LO];
			term_rs_val <= cfg_r[lun_r].rs_val;
			matrix_mode <= matrix_r;
			standby <= cs_n && busy_r == 16'h0000;
			bus_idle <= idle_c;
			bus.dq_d <= cmd_r;
			// drive only in a data output burst while enabled
			bus.dq_d_oe_n <= !(cyc_nxt == DTC_CYC_DOUT && !cs_n);
			bus.dqs_d <= rs_n;
			bus.dqs_d_oe_n <= !(cyc_nxt == DTC_CYC_DOUT && !cs_n);
			bus.ready_busy_n <= busy_r == 16'h0000;
		end
	end
endmodule

// >>> sim/die_termination_control_test.sv
// self-checking bench joining host and target ends
`timescale 1ns/1ps
`include "dtc_defs.svh"
module die_termination_control_test;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	logic [1:0]  req_kind = 2'h0;
	logic [7:0]  req_cmd = 8'h00;
	logic [7:0]  req_addr = 8'h00;
	logic [31:0] req_data = 32'h0;
	logic        req_release = 1'b0;
	logic        req_ready;
	logic [1:0]  term_dq_on, term_rs_on;
	logic [1:0]  seen_dq = 2'h0;
	logic [1:0]  seen_rs = 2'h0;
	logic [3:0]  term_dq_val, dq_val;
	logic [7:0]  term_rs_val, rs_val;
	logic        matrix_mode, standby, bus_idle;
	int          mismatches = 0;
	int          comparisons = 0;

	dtc_bus_if bus_w ();
	dtc_target #(.NUM_LUNS(2), .MY_VOLUME(0)) u_dtc_target (
		.ref_clk(ref_clk), .rst(rst), .bus(bus_w),
		.term_dq_on(term_dq_on), .term_rs_on(term_rs_on),
		.term_dq_val(term_dq_val), .term_rs_val(term_rs_val),
		.matrix_mode(matrix_mode), .standby(standby), .bus_idle(bus_idle));
	dtc_host u_dtc_host (
		.ref_clk(ref_clk), .rst(rst), .bus(bus_w),
		.req_valid(req_valid), .req_kind(req_kind), .req_cmd(req_cmd),
		.req_addr(req_addr), .req_data(req_data),
		.req_release(req_release), .req_ready(req_ready));
	dtc_bus_checker u_dtc_bus_checker (
		.ref_clk(ref_clk), .rst(rst), .chip_sel_n(bus_w.chip_sel_n),
		.ale(bus_w.ale), .cle(bus_w.cle),
		.read_strobe_n(bus_w.read_strobe_n), .dqs_h(bus_w.dqs_h),
		.dqs_h_oe_n(bus_w.dqs_h_oe_n), .dq_d_oe_n(bus_w.dq_d_oe_n),
		.dqs_d_oe_n(bus_w.dqs_d_oe_n), .ready_busy_n(bus_w.ready_busy_n));

	// 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	// remember which LUNs terminated and with what value
	always @(posedge ref_clk) begin
		seen_dq <= seen_dq | term_dq_on;
		seen_rs <= seen_rs | term_rs_on;
		if (|term_dq_on)
			dq_val <= term_dq_val;
		if (|term_rs_on)
			rs_val <= term_rs_val;
	end

	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask

	task conclude;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one host request, returns once the host is ready again
	task send(input logic [1:0] k, input logic [7:0] c, input logic [7:0] a,
		input logic [31:0] d);
		@(negedge ref_clk);
		while (req_ready !== 1'b1)
			@(negedge ref_clk);
		req_kind = k;
		req_cmd = c;
		req_addr = a;
		req_data = d;
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (req_ready !== 1'b1)
			@(negedge ref_clk);
	endtask

	// reset command, then wait out the busy time
	task rst_cmd(input logic [7:0] c);
		send(2'h0, c, 8'h00, 32'h0);
		repeat (`DTC_BUSY_CYC + 10) @(negedge ref_clk);
	endtask

	// data transfer, then judge which LUNs terminated
	task xfer(input logic [7:0] c, input logic [7:0] a, input logic [1:0] edq,
		input logic [1:0] ers);
		@(negedge ref_clk);
		seen_dq = 2'h0;
		seen_rs = 2'h0;
		send(2'h2, c, a, 32'ha55ac33c);
		repeat (8) @(negedge ref_clk);
		chk(8'(seen_dq), 8'(edq), "data termination");
		chk(8'(seen_rs), 8'(ers), "read strobe termination");
	endtask

	task t_reset;
		repeat (6) @(negedge ref_clk);
		chk(8'(matrix_mode), 8'h00, "matrix after reset");
		chk(8'(standby), 8'h01, "standby after reset");
		$display("test reset done");
	endtask

	task t_self;
		rst_cmd(`DTC_CMD_RESET);
		send(2'h2, `DTC_CMD_SET_FEATURES, 8'h02, 32'h01000000);
		xfer(`DTC_CMD_PROG, 8'h01, 2'b01, 2'b00);
		xfer(`DTC_CMD_READ, 8'h00, 2'b00, 2'b01);
		chk(8'(matrix_mode), 8'h00, "self mode");
		chk(8'(bus_idle), 8'h01, "idle");
		$display("test self done");
	endtask

	task t_matrix;
		// last configured LUN is the one whose values are shown
		send(2'h2, `DTC_CMD_MATRIX, 8'h01, 32'h02004000);
		send(2'h2, `DTC_CMD_MATRIX, 8'h00, 32'h01004203);
		chk(8'(matrix_mode), 8'h01, "matrix mode");
		send(2'h1, `DTC_CMD_VOL_SELECT, 8'h00, 32'h0);
		xfer(`DTC_CMD_PROG, 8'h01, 2'b01, 2'b00);
		chk(8'(dq_val), 8'h02, "input value");
		xfer(`DTC_CMD_READ, 8'h01, 2'b01, 2'b01);
		chk(8'(dq_val), 8'h04, "output value");
		chk(rs_val, 8'h03, "strobe value");
		send(2'h1, `DTC_CMD_VOL_SELECT, 8'h01, 32'h0);
		xfer(`DTC_CMD_READ, 8'h00, 2'b10, 2'b00);
		send(2'h1, `DTC_CMD_VOL_SELECT, 8'h02, 32'h0);
		xfer(`DTC_CMD_READ, 8'h00, 2'b00, 2'b00);
		$display("test matrix done");
	endtask

	task t_resets;
		rst_cmd(`DTC_CMD_RESET);
		send(2'h1, `DTC_CMD_VOL_SELECT, 8'h01, 32'h0);
		xfer(`DTC_CMD_READ, 8'h00, 2'b10, 2'b00);
		// address LUN1 so that the full reset clears it
		send(2'h2, `DTC_CMD_MATRIX, 8'h01, 32'h02004000);
		rst_cmd(`DTC_CMD_FULL_RESET);
		send(2'h1, `DTC_CMD_VOL_SELECT, 8'h01, 32'h0);
		xfer(`DTC_CMD_READ, 8'h00, 2'b00, 2'b00);
		$display("test resets done");
	endtask

	// deselect while busy: standby waits for the LUNs
	task t_standby;
		send(2'h0, `DTC_CMD_RESET, 8'h00, 32'h0);
		req_release = 1'b1;
		while (bus_w.chip_sel_n !== 1'b1)
			@(negedge ref_clk);
		req_release = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(8'(standby), 8'h00, "standby while busy");
		repeat (`DTC_BUSY_CYC + 10) @(negedge ref_clk);
		chk(8'(standby), 8'h01, "standby when done");
		chk(8'(bus_w.dq_d_oe_n), 8'h01, "released");
		$display("test standby done");
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		t_reset;
		t_self;
		t_matrix;
		t_resets;
		t_standby;
		conclude;
	end

	// watchdog against a hung handshake
	initial begin
		#300000;
		mismatches++;
		conclude;
	end
endmodule

// >>> sim/dtc_bus_sva.sv
// bus pin checks between host end and target end
`timescale 1ns/1ps
module dtc_bus_checker (
	input logic ref_clk,
	input logic rst,
	input logic chip_sel_n,
	input logic ale,
	input logic cle,
	input logic read_strobe_n,
	input logic dqs_h,
	input logic dqs_h_oe_n,
	input logic dq_d_oe_n,
	input logic dqs_d_oe_n,
	input logic ready_busy_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// deselected target lets go of data and strobe
	a_cs_high_quiet: assert property (
		chip_sel_n [*5] |-> dq_d_oe_n && dqs_d_oe_n)
		else $error("target drives while deselected");
	// no data out on a quiet bus
	a_idle_no_output: assert property (
		(!chip_sel_n && !ale && !cle && read_strobe_n) [*8] |-> dq_d_oe_n)
		else $error("target drives on idle bus");
	// data and strobe driven together
	a_oe_pair: assert property (
		dq_d_oe_n == dqs_d_oe_n)
		else $error("data and strobe enables differ");
	// busy ends within 60 cycles, three times the reset time
	a_busy_bounded: assert property (
		$fell(ready_busy_n) |-> ##[1:60] ready_busy_n)
		else $error("busy never ends");
	// command and address cycles never overlap
	a_latch_exclusive: assert property (
		!(ale && cle))
		else $error("both latch enables high");
	// deselected bus rests idle
	a_cs_high_host: assert property (
		chip_sel_n |-> !ale && !cle && read_strobe_n)
		else $error("host active while deselected");
	// bus idle in the cycle before deselect
	a_idle_before_cs: assert property (
		$rose(chip_sel_n) |-> $past(read_strobe_n) && !$past(ale)
			&& !$past(cle))
		else $error("deselect without idle");
	// strobe high or released before deselect
	a_idle_dqs_high: assert property (
		$rose(chip_sel_n) |-> $past(dqs_h) || $past(dqs_h_oe_n))
		else $error("strobe low at deselect");
endmodule
